/* File: design/mfo_select.sv */
// Multi-function output select: relay and two digital output terminals.
// Assumes analog, torque and drive status inputs synchronous to ref_clk_i.
module mfo_select #(
	parameter int TICK_CYCLES = mfo_pkg::TICK_CYCLES
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [15:0]           addr_i,
	input  wire logic [15:0]           wr_data_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [15:0]           rd_data_o,
	input  wire mfo_pkg::drive_status_s drive_i,
	input  wire logic [15:0]           analog_channel_one_i,
	input  wire logic [15:0]           analog_channel_two_i,
	input  wire logic [15:0]           torque_i,
	output logic                       relay_output_o,
	output logic                       digital_output_one_o,
	output logic                       digital_output_two_o,
	output logic                       irq_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] pol_mask;
		logic [7:0]  relay_fn;
		logic [7:0]  out_one_fn;
		logic [7:0]  out_two_fn;
		logic        ch_sel;
		logic [15:0] high_thr;
		logic [15:0] low_thr;
		logic [15:0] tq3_level;
		logic [15:0] tq3_time;
		logic [15:0] tq4_level;
		logic [15:0] tq4_time;
		logic [mfo_pkg::NUM_EVENTS-1:0] irq_stat;
		logic [mfo_pkg::NUM_EVENTS-1:0] irq_en;
		logic [mfo_pkg::NUM_EVENTS-1:0] ev_prev;
		logic [15:0] rd_data;
		logic [31:0] tick_cnt;
		logic        tick;
		logic [2:0]  outs;
	} state_s;

	state_s r;
	state_s r_nxt;

	logic        fault;
	logic        win_on;
	logic        ot3;
	logic        ot4;
	logic [15:0] ain_sel;
	logic [mfo_pkg::NUM_EVENTS-1:0] events;
	logic [2:0]  levels;
	logic [2:0]  inv_bits;
	logic [7:0]  fn_sel [3];

	// ****************************************
	// Function decode
	// ****************************************
	function automatic logic fn_level(input logic [7:0] fn, input logic run, input logic rev,
		input logic flt, input logic win, input logic t3, input logic t4);
		logic lvl;
		lvl = 1'b0;
		case (fn)
			mfo_pkg::FN_RUNNING:  lvl = run;
			mfo_pkg::FN_SAFETY_A: lvl = flt;
			mfo_pkg::FN_SAFETY_B: lvl = !flt;
			mfo_pkg::FN_ANALOG:   lvl = win;
			mfo_pkg::FN_TORQUE3:  lvl = t3;
			mfo_pkg::FN_TORQUE4:  lvl = t4;
			mfo_pkg::FN_FWD_RUN:  lvl = run && !rev;
			mfo_pkg::FN_REV_RUN:  lvl = run && rev;
			default:              lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	assign fault = drive_i.safe_torque_off_state || (|drive_i.safety_loss_faults);
	assign ain_sel = r.ch_sel ? analog_channel_two_i : analog_channel_one_i;

	// ****************************************
	// Measurement helpers
	// ****************************************
	window_hyst u_window (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.level_i   (ain_sel),
		.high_i    (r.high_thr),
		.low_i     (r.low_thr),
		.active_o  (win_on)
	);

	torque_detect u_tq3 (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_i    (r.tick),
		.torque_i  (torque_i),
		.level_i   (r.tq3_level),
		.time_i    (r.tq3_time),
		.detect_o  (ot3)
	);

	torque_detect u_tq4 (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_i    (r.tick),
		.torque_i  (torque_i),
		.level_i   (r.tq4_level),
		.time_i    (r.tq4_time),
		.detect_o  (ot4)
	);

	// ****************************************
	// Terminal levels and polarity
	// ****************************************
	assign fn_sel[0] = r.relay_fn;
	assign fn_sel[1] = r.out_one_fn;
	assign fn_sel[2] = r.out_two_fn;
	assign inv_bits = {r.pol_mask[mfo_pkg::MASK_BIT_OUT_TWO], r.pol_mask[mfo_pkg::MASK_BIT_OUT_ONE],
		r.pol_mask[mfo_pkg::MASK_BIT_RELAY]};

	for (genvar g = 0; g < 3; g++) begin : g_term
		assign levels[g] = fn_level(fn_sel[g], drive_i.run, drive_i.reverse, fault,
			win_on, ot3, ot4) ^ inv_bits[g];
	end

	assign events = {win_on, fault, ot4, ot3};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_nxt = r;
		r_nxt.outs = levels;
		r_nxt.rd_data = '0;
		r_nxt.ev_prev = events;
		if (r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			r_nxt.tick_cnt = '0;
			r_nxt.tick = 1'b1;
		end else begin
			r_nxt.tick_cnt = r.tick_cnt + 32'h00000001;
			r_nxt.tick = 1'b0;
		end
		if (wr_i) begin
			case (addr_i)
				mfo_pkg::ADDR_POLARITY_MASK: r_nxt.pol_mask = wr_data_i;
				mfo_pkg::ADDR_RELAY_FN:      r_nxt.relay_fn = wr_data_i[7:0];
				mfo_pkg::ADDR_OUT_ONE_FN:    r_nxt.out_one_fn = wr_data_i[7:0];
				mfo_pkg::ADDR_OUT_TWO_FN:    r_nxt.out_two_fn = wr_data_i[7:0];
				mfo_pkg::ADDR_CH_SEL:        r_nxt.ch_sel = wr_data_i[0];
				mfo_pkg::ADDR_HIGH_THR:      r_nxt.high_thr = wr_data_i;
				mfo_pkg::ADDR_LOW_THR:       r_nxt.low_thr = wr_data_i;
				mfo_pkg::ADDR_TQ3_LEVEL:     r_nxt.tq3_level = wr_data_i;
				mfo_pkg::ADDR_TQ3_TIME:      r_nxt.tq3_time = wr_data_i;
				mfo_pkg::ADDR_TQ4_LEVEL:     r_nxt.tq4_level = wr_data_i;
				mfo_pkg::ADDR_TQ4_TIME:      r_nxt.tq4_time = wr_data_i;
				mfo_pkg::ADDR_IRQ_CLEAR:
					r_nxt.irq_stat = r.irq_stat & ~wr_data_i[mfo_pkg::NUM_EVENTS-1:0];
				mfo_pkg::ADDR_IRQ_ENABLE:
					r_nxt.irq_en = wr_data_i[mfo_pkg::NUM_EVENTS-1:0];
				default: ;
			endcase
		end
		// Rising edges set status after any clear, so a coincident event survives
		r_nxt.irq_stat = r_nxt.irq_stat | (events & ~r.ev_prev);
		if (rd_i) begin
			case (addr_i)
				mfo_pkg::ADDR_POLARITY_MASK: r_nxt.rd_data = r.pol_mask;
				mfo_pkg::ADDR_RELAY_FN:      r_nxt.rd_data = {8'h00, r.relay_fn};
				mfo_pkg::ADDR_OUT_ONE_FN:    r_nxt.rd_data = {8'h00, r.out_one_fn};
				mfo_pkg::ADDR_OUT_TWO_FN:    r_nxt.rd_data = {8'h00, r.out_two_fn};
				mfo_pkg::ADDR_CH_SEL:        r_nxt.rd_data = {15'h0000, r.ch_sel};
				mfo_pkg::ADDR_HIGH_THR:      r_nxt.rd_data = r.high_thr;
				mfo_pkg::ADDR_LOW_THR:       r_nxt.rd_data = r.low_thr;
				mfo_pkg::ADDR_TQ3_LEVEL:     r_nxt.rd_data = r.tq3_level;
				mfo_pkg::ADDR_TQ3_TIME:      r_nxt.rd_data = r.tq3_time;
				mfo_pkg::ADDR_TQ4_LEVEL:     r_nxt.rd_data = r.tq4_level;
				mfo_pkg::ADDR_TQ4_TIME:      r_nxt.rd_data = r.tq4_time;
				mfo_pkg::ADDR_IRQ_STATUS:    r_nxt.rd_data = {12'h000, r.irq_stat};
				mfo_pkg::ADDR_IRQ_ENABLE:    r_nxt.rd_data = {12'h000, r.irq_en};
				mfo_pkg::ADDR_LIVE_STATUS:   r_nxt.rd_data = {9'h000, r.outs, events};
				default:                     r_nxt.rd_data = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.pol_mask <= mfo_pkg::POLARITY_MASK_RST;
			r.relay_fn <= mfo_pkg::FN_RST;
			r.out_one_fn <= mfo_pkg::FN_RST;
			r.out_two_fn <= mfo_pkg::FN_RST;
			r.high_thr <= mfo_pkg::HIGH_THR_RST;
			r.low_thr <= mfo_pkg::LOW_THR_RST;
			r.tq3_level <= mfo_pkg::TQ_LEVEL_RST;
			r.tq3_time <= mfo_pkg::TQ_TIME_RST;
			r.tq4_level <= mfo_pkg::TQ_LEVEL_RST;
			r.tq4_time <= mfo_pkg::TQ_TIME_RST;
		end else begin
			r <= r_nxt;
		end
	end

	assign relay_output_o = r.outs[0];
	assign digital_output_one_o = r.outs[1];
	assign digital_output_two_o = r.outs[2];
	assign irq_o = |(r.irq_stat & r.irq_en);
	assign rd_data_o = r.rd_data;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_relay_plain(logic [7:0] code);
		r.relay_fn == code && !r.pol_mask[mfo_pkg::MASK_BIT_RELAY];
	endsequence

	a_safety_pol_a: assert property (s_relay_plain(mfo_pkg::FN_SAFETY_A) |=>
		relay_output_o == $past(fault))
		else $error("Safety polarity A level wrong");
	a_safety_pol_b: assert property (s_relay_plain(mfo_pkg::FN_SAFETY_B) |=>
		relay_output_o == !$past(fault))
		else $error("Safety polarity B level wrong");
	a_window_output: assert property (r.out_one_fn == mfo_pkg::FN_ANALOG &&
		!r.pol_mask[mfo_pkg::MASK_BIT_OUT_ONE] |=> digital_output_one_o == $past(win_on))
		else $error("Analog window not on digital output one");
	a_window_hyst: assert property (ain_sel <= r.high_thr && ain_sel >= r.low_thr &&
		$stable(r.high_thr) && $stable(r.low_thr) ##1 ain_sel <= r.high_thr &&
		ain_sel >= r.low_thr |=> $stable(win_on))
		else $error("Window state moved inside hysteresis band");
	a_channel_sel: assert property (!r.ch_sel && analog_channel_one_i > r.high_thr &&
		!$changed(r.ch_sel) |=> win_on)
		else $error("Channel one above high did not turn window on");
	a_torque_three: assert property ($rose(ot3) |-> $past(torque_i > r.tq3_level, 1) &&
		r.tq3_time < 16'hffff)
		else $error("Over-torque three without overload");
	a_torque_four: assert property (torque_i <= r.tq4_level |=> !ot4)
		else $error("Over-torque four held without overload");
	a_fwd_run: assert property (s_relay_plain(mfo_pkg::FN_FWD_RUN) |=>
		relay_output_o == $past(drive_i.run && !drive_i.reverse))
		else $error("Forward run indication wrong");
	a_rev_run: assert property (s_relay_plain(mfo_pkg::FN_REV_RUN) |=>
		relay_output_o == $past(drive_i.run && drive_i.reverse))
		else $error("Reverse run indication wrong");
	a_mask_invert: assert property (r.out_two_fn == mfo_pkg::FN_FWD_RUN &&
		r.pol_mask[mfo_pkg::MASK_BIT_OUT_TWO] |=> digital_output_two_o ==
		!$past(drive_i.run && !drive_i.reverse))
		else $error("Mask bit four did not invert output two");
	a_running_relay: assert property (r.relay_fn == mfo_pkg::FN_RUNNING |=>
		relay_output_o == ($past(drive_i.run) ^ $past(r.pol_mask[mfo_pkg::MASK_BIT_RELAY])))
		else $error("Running relay level wrong");
	// Event edge must land in status even when a clear hits the same cycle
	a_irq_level: assert property (|(events & ~r.ev_prev) |=>
		(r.irq_stat & $past(events & ~r.ev_prev)) == $past(events & ~r.ev_prev))
		else $error("Event edge did not set its status bit");

endmodule

/* File: inc/mfo_pkg.sv */
// Package for the multi-function output select block.
// Assumes one 50 MHz clock and a plain register port with 16-bit addresses.
// Functional notes
// - Analog function holds output inside threshold window
// - On above high, off below low; 50%/10%
// - Selector picks analog channel one or two
// - Code 73: torque over level three too long
// - Code 74: torque over level four too long
// - Code 75: closed while running forward
// - Code 76: closed while running reverse
// - Mask bits 0,3,4 invert relay, outputs one, two
// - Running relay energises on run, inverted by mask
package mfo_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] ADDR_POLARITY_MASK = 16'h0212;
	localparam logic [15:0] ADDR_RELAY_FN      = 16'h0300;
	localparam logic [15:0] ADDR_OUT_ONE_FN    = 16'h0301;
	localparam logic [15:0] ADDR_OUT_TWO_FN    = 16'h0302;
	localparam logic [15:0] ADDR_CH_SEL        = 16'h0303;
	localparam logic [15:0] ADDR_HIGH_THR      = 16'h0304;
	localparam logic [15:0] ADDR_LOW_THR       = 16'h0305;
	localparam logic [15:0] ADDR_TQ3_LEVEL     = 16'h0306;
	localparam logic [15:0] ADDR_TQ3_TIME      = 16'h0307;
	localparam logic [15:0] ADDR_TQ4_LEVEL     = 16'h0308;
	localparam logic [15:0] ADDR_TQ4_TIME      = 16'h0309;
	localparam logic [15:0] ADDR_IRQ_STATUS    = 16'h0310;
	localparam logic [15:0] ADDR_IRQ_CLEAR     = 16'h0311;
	localparam logic [15:0] ADDR_IRQ_ENABLE    = 16'h0312;
	localparam logic [15:0] ADDR_LIVE_STATUS   = 16'h0313;

	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [15:0] POLARITY_MASK_RST  = 16'h0000;
	localparam logic [15:0] HIGH_THR_RST       = 16'h01f4;
	localparam logic [15:0] LOW_THR_RST        = 16'h0064;
	localparam logic [15:0] TQ_LEVEL_RST       = 16'h0096;
	localparam logic [15:0] TQ_TIME_RST        = 16'h0001;
	localparam logic [7:0]  FN_RST             = 8'h00;
	localparam int          MASK_BIT_RELAY     = 0;
	localparam int          MASK_BIT_OUT_ONE   = 3;
	localparam int          MASK_BIT_OUT_TWO   = 4;
	localparam int          NUM_EVENTS         = 4;

	// ****************************************
	// Function codes
	// ****************************************
	localparam logic [7:0] FN_RUNNING   = 8'h01;
	localparam logic [7:0] FN_SAFETY_A  = 8'h42;
	localparam logic [7:0] FN_ANALOG    = 8'h43;
	localparam logic [7:0] FN_SAFETY_B  = 8'h44;
	localparam logic [7:0] FN_TORQUE3   = 8'h49;
	localparam logic [7:0] FN_TORQUE4   = 8'h4a;
	localparam logic [7:0] FN_FWD_RUN   = 8'h4b;
	localparam logic [7:0] FN_REV_RUN   = 8'h4c;

	// ****************************************
	// Timing: detection time unit
	// ****************************************
	localparam int CLK_HZ        = 50000000;
	localparam int TIME_UNIT_MS  = 100;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TIME_UNIT_MS;

	typedef struct packed {
		logic       run;
		logic       reverse;
		logic       safe_torque_off_state;
		logic [2:0] safety_loss_faults;
	} drive_status_s;

endpackage

/* File: design/window_hyst.sv */
// Hysteresis window comparator for the analog level function.
// Assumes thresholds and sample share one unit of 0.1 percent.
module window_hyst (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] level_i,
	input  wire logic [15:0] high_i,
	input  wire logic [15:0] low_i,
	output logic             active_o
);

	typedef struct packed {
		logic on;
	} hyst_s;

	hyst_s r;
	hyst_s r_nxt;

	always_comb begin
		r_nxt = r;
		if (level_i > high_i) begin
			r_nxt.on = 1'b1;
		end else if (level_i < low_i) begin
			r_nxt.on = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign active_o = r.on;

endmodule

/* File: design/torque_detect.sv */
// Over-torque detector: torque above level for longer than a time.
// Assumes tick_i pulses once per detection time unit.
module torque_detect (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] torque_i,
	input  wire logic [15:0] level_i,
	input  wire logic [15:0] time_i,
	output logic             detect_o
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        det;
	} det_s;

	det_s r;
	det_s r_nxt;

	always_comb begin
		r_nxt = r;
		if (torque_i <= level_i) begin
			r_nxt.cnt = '0;
			r_nxt.det = 1'b0;
		end else begin
			// Saturate so a long overload never wraps back to idle
			if (tick_i && r.cnt != 16'hffff) begin
				r_nxt.cnt = r.cnt + 16'h0001;
			end
			r_nxt.det = r_nxt.cnt > time_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign detect_o = r.det;

endmodule

/* File: verif/relay_bank.sv */
// Model of the field devices wired to the three output terminals.
// Assumes terminal levels are registered on ref_clk_i; 1 = closed.
module relay_bank (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       relay_i,
	input  wire logic       do_one_i,
	input  wire logic       do_two_i,
	output logic      [2:0] coil_o,
	output logic      [7:0] pickups_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Coil state follows the terminals
	// ****************************************
	// Contacts settle one cycle later, as a real contactor lags its coil
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			coil_o    <= 3'h0;
			pickups_o <= 8'h00;
		end else begin
			coil_o <= {do_two_i, do_one_i, relay_i};
			if (relay_i && !coil_o[0]) begin
				pickups_o <= pickups_o + 8'h01;
			end
		end
	end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the multi-function output select block.
// Assumes the design files and the package are compiled before this file.
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  ref_clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic [15:0]           addr_i = 16'h0000;
	logic [15:0]           wr_data_i = 16'h0000;
	logic                  wr_i = 1'b0;
	logic                  rd_i = 1'b0;
	logic [15:0]           rd_data_o;
	mfo_pkg::drive_status_s drive_i = '0;
	logic [15:0]           ch1 = 16'h0000;
	logic [15:0]           ch2 = 16'h0000;
	logic [15:0]           torque_i = 16'h0000;
	logic                  relay_o, dout_one, dout_two, irq_o;
	logic [2:0]            coil;
	logic [7:0]            pickups;
	int                    failures = 0;
	int                    comparisons = 0;
	int                    cycles = 0;
	logic [31:0]           seed = 32'd45;
	logic [7:0]            codes [6] = '{8'h01, 8'h42, 8'h44, 8'h4b, 8'h4c, 8'h10};

	mfo_select #(.TICK_CYCLES(4)) DUT (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .drive_i(drive_i),
		.analog_channel_one_i(ch1), .analog_channel_two_i(ch2), .torque_i(torque_i),
		.relay_output_o(relay_o), .digital_output_one_o(dout_one),
		.digital_output_two_o(dout_two), .irq_o(irq_o));

	relay_bank far_side (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .relay_i(relay_o), .do_one_i(dout_one),
		.do_two_i(dout_two), .coil_o(coil), .pickups_o(pickups));

	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic exp_level(input logic [7:0] c, input mfo_pkg::drive_status_s d);
		logic flt;
		flt = d.safe_torque_off_state | (|d.safety_loss_faults);
		case (c)
			mfo_pkg::FN_RUNNING:  return d.run;
			mfo_pkg::FN_SAFETY_A: return flt;
			mfo_pkg::FN_SAFETY_B: return !flt;
			mfo_pkg::FN_FWD_RUN:  return d.run & !d.reverse;
			mfo_pkg::FN_REV_RUN:  return d.run & d.reverse;
			default:              return 1'b0;
		endcase
	endfunction

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		check(name, exp, rd_data_o);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic set_analog(input logic [15:0] a1, input logic [15:0] a2);
		@(posedge ref_clk_i);
		ch1 <= a1;
		ch2 <= a2;
		wait_cyc(4);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Cut a hang short; the whole run needs under a thousand cycles
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		logic [7:0]             c [3];
		logic [15:0]            mask;
		mfo_pkg::drive_status_s d;
		wait_cyc(8);
		rst_i <= 1'b0;
		rd(mfo_pkg::ADDR_POLARITY_MASK, 16'h0000, "mask reset");
		rd(mfo_pkg::ADDR_HIGH_THR, 16'h01f4, "high reset");
		rd(mfo_pkg::ADDR_LOW_THR, 16'h0064, "low reset");
		rd(16'h0400, 16'h0000, "unmapped");
		rd(mfo_pkg::ADDR_IRQ_CLEAR, 16'h0000, "clear reads zero");
		$display("test registers done");

		for (int i = 0; i < 40; i++) begin
			for (int k = 0; k < 3; k++) begin
				seed = xorshift(seed);
				c[k] = codes[seed % 6];
			end
			seed = xorshift(seed);
			mask = seed[15:0] & 16'h001f;
			wr(mfo_pkg::ADDR_RELAY_FN, {8'h00, c[0]});
			wr(mfo_pkg::ADDR_OUT_ONE_FN, {8'h00, c[1]});
			wr(mfo_pkg::ADDR_OUT_TWO_FN, {8'h00, c[2]});
			wr(mfo_pkg::ADDR_POLARITY_MASK, mask);
			seed = xorshift(seed);
			d = seed[5:0] & ((i % 4 == 0) ? 6'h3f : 6'h30);
			@(posedge ref_clk_i);
			drive_i <= d;
			wait_cyc(4);
			check("relay", {15'h0, exp_level(c[0], d) ^ mask[0]}, {15'h0, coil[0]});
			check("output one", {15'h0, exp_level(c[1], d) ^ mask[3]}, {15'h0, coil[1]});
			check("output two", {15'h0, exp_level(c[2], d) ^ mask[4]}, {15'h0, coil[2]});
		end
		$display("test random functions done");

		// Running relay, both mask senses
		wr(mfo_pkg::ADDR_RELAY_FN, 16'h0001);
		for (int m = 0; m < 2; m++) begin
			wr(mfo_pkg::ADDR_POLARITY_MASK, m[0] ? 16'h0007 : 16'h0006);
			for (int r = 0; r < 2; r++) begin
				@(posedge ref_clk_i);
				drive_i <= r[0] ? 6'h20 : 6'h00;
				wait_cyc(4);
				check("running relay", {15'h0, r[0] ^ m[0]}, {15'h0, coil[0]});
			end
		end
		$display("test running relay done");

		// Analog window on channel two, with irq
		@(posedge ref_clk_i);
		drive_i <= 6'h00;
		wr(mfo_pkg::ADDR_POLARITY_MASK, 16'h0000);
		wr(mfo_pkg::ADDR_RELAY_FN, {8'h00, mfo_pkg::FN_ANALOG});
		wr(mfo_pkg::ADDR_CH_SEL, 16'h0001);
		wr(mfo_pkg::ADDR_IRQ_ENABLE, 16'h0008);
		wr(mfo_pkg::ADDR_IRQ_CLEAR, 16'h000f);
		set_analog(16'h0384, 16'h012c);
		check("other channel ignored", 16'h0000, {15'h0, coil[0]});
		set_analog(16'h0000, 16'h01f4);
		check("at high stays off", 16'h0000, {15'h0, coil[0]});
		set_analog(16'h0000, 16'h01f5);
		check("above high on", 16'h0001, {15'h0, coil[0]});
		check("irq window", 16'h0001, {15'h0, irq_o});
		set_analog(16'h0000, 16'h0064);
		check("inside window holds", 16'h0001, {15'h0, coil[0]});
		wr(mfo_pkg::ADDR_IRQ_CLEAR, 16'h0008);
		wait_cyc(1);
		check("irq cleared", 16'h0000, {15'h0, irq_o});
		set_analog(16'h0000, 16'h0063);
		check("below low off", 16'h0000, {15'h0, coil[0]});
		wr(mfo_pkg::ADDR_IRQ_ENABLE, 16'h0000);
		set_analog(16'h0000, 16'h0258);
		check("irq masked", 16'h0000, {15'h0, irq_o});
		rd(mfo_pkg::ADDR_IRQ_STATUS, 16'h0008, "status sticky");
		$display("test analog window done");

		// Over-torque three and four
		wr(mfo_pkg::ADDR_OUT_ONE_FN, {8'h00, mfo_pkg::FN_TORQUE3});
		wr(mfo_pkg::ADDR_OUT_TWO_FN, {8'h00, mfo_pkg::FN_TORQUE4});
		wr(mfo_pkg::ADDR_TQ4_LEVEL, 16'h00c8);
		wr(mfo_pkg::ADDR_TQ4_TIME, 16'h0002);
		@(posedge ref_clk_i);
		torque_i <= 16'h00b4;
		wait_cyc(3);
		check("ot3 too early", 16'h0000, {15'h0, coil[1]});
		wait_cyc(30);
		check("ot3 detect", 16'h0001, {15'h0, coil[1]});
		check("ot4 below level", 16'h0000, {15'h0, coil[2]});
		@(posedge ref_clk_i);
		torque_i <= 16'h00fa;
		wait_cyc(5);
		check("ot4 too early", 16'h0000, {15'h0, coil[2]});
		wait_cyc(30);
		check("ot4 detect", 16'h0001, {15'h0, coil[2]});
		// Window on, no fault, both detectors on; all three terminals closed
		rd(mfo_pkg::ADDR_LIVE_STATUS, 16'h007b, "live status");
		@(posedge ref_clk_i);
		torque_i <= 16'h0000;
		wait_cyc(5);
		check("torque released", 16'h0000, {14'h0, coil[2:1]});
		$display("test torque done");
		print_verdict();
	end
endmodule
